// >>> rtl/rcesm_pkg.sv
// Purpose: constants for the ram ecc error status and mask bank
// Assumes: byte addresses of configuration space, 32-bit registers
// Notes: shared by the bank and its sticky register leaf
package rcesm_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CORR_STATUS_OFS = 12'h700; // correctable status
  localparam logic [11:0] CORR_MASK_OFS = 12'h704; // correctable mask
  localparam logic [11:0] UNC_STATUS_OFS = 12'h708; // uncorrectable status
  localparam logic [11:0] UNC_MASK_OFS = 12'h70c; // uncorrectable mask
  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CORR_STATUS_BITS = 32'h000ff1c5; // bits 0,2,6-8,12-19
  localparam logic [31:0] CORR_MASK_BITS = 32'h000ff1c7; // plus test bit 1
  localparam logic [31:0] UNC_BITS = 32'h000ff1c4; // bits 2,6-8,12-19
  localparam logic [31:0] CORR_MASK_RST = 32'h000ff1c7; // all masks default 1
  localparam logic [31:0] UNC_MASK_RST = 32'h000ff1c4; // all masks default 1
  localparam logic [31:0] STATUS_RST = 32'h00000000; // status clear
  // ----------------------------------------------------------------
  // station header bit positions and leading ports
  // ----------------------------------------------------------------
  localparam int HDR_BIT_STN0 = 8; // header ram of station 0
  localparam int HDR_BIT_STN4 = 12; // header ram of station 4
  localparam int HDR_BIT_STN5 = 13; // header ram of station 5
  localparam logic [2:0] STN0 = 3'h0; // station numbers
  localparam logic [2:0] STN4 = 3'h4;
  localparam logic [2:0] STN5 = 3'h5;
  localparam logic [4:0] LEAD_PORT0 = 5'h00; // station-leading ports
  localparam logic [4:0] LEAD_PORT16 = 5'h10;
  localparam logic [4:0] LEAD_PORT20 = 5'h14;
endpackage : rcesm_pkg

// >>> rtl/rcesm_sticky_reg.sv
// Purpose: sticky write-one-to-clear status vector
// Assumes: rst is the power-on or fundamental reset only
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
module rcesm_sticky_reg (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] setBits,
  input wire logic [31:0] clrBits,
  input wire logic [31:0] implBits,
  output logic [31:0] status
);
  import rcesm_pkg::*;
  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  wire logic [31:0] next_status = ((status & ~clrBits) | setBits) & implBits; // set wins
  // state update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status <= STATUS_RST;
    end else begin
      status <= next_status;
    end
  end
endmodule : rcesm_sticky_reg

// >>> rtl/rcesm_bank.sv
// Purpose: ram ecc error status and mask registers with message request
// Assumes: configuration accesses are single-cycle strobes on sys_clk
// Notes: rst is fundamental reset; hot and link resets never reach here
//
// Functional notes
// R1 - egress port checks ecc, its station reports
// R2 - remote ram error flags ingress station bit
// R3 - link list 2-bit errors set bits 2,6,7
// R4 - header 2-bit errors set bits 8,12,13
// R5 - queue link list errors set 14,15,18
// R6 - retry, ingress list, data ram: 16,17,19
// R7 - status sticky, write one clears, resets 0
// R8 - uncorrectable mask one suppresses, defaults one
// R9 - correctable mask bits writable, default one
// R10 - mask bit 1 test; uncorrectable 1:0 zero
// R11 - reachable at leading ports or management port
// R12 - legacy non_transparent: via virtual interface
// R13 - message only when uncorrectable mask clear; the code also requests one for an unmasked correctable status bit
// R14 - message needs internal error status set
// R15 - fatal/nonfatal need their reporting enables
// R16 - correctable status set by soft errors, w1c
// R17 - bit 0 completion fifo overflow, mask one
// R18 - sticky fields survive hot and link resets
// R19 - reserved bits read zero, writes ignored
`timescale 1ns/1ns
module rcesm_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [11:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  input wire logic virtSwitchMode,
  input wire logic fromMgmtPort,
  input wire logic fromNtVirtual,
  input wire logic leadPortIsNt,
  input wire logic [4:0] portNum,
  input wire logic [31:0] corrEvent,
  input wire logic [31:0] uncEvent,
  input wire logic remoteHdrErr,
  input wire logic [2:0] remoteStation,
  input wire logic uncIntErrStatus,
  input wire logic intErrFatal,
  input wire logic fatalReportEn,
  input wire logic nonFatalReportEn,
  output logic errFatalMsg,
  output logic errNonFatalMsg
);
  import rcesm_pkg::*;
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // byte enables to a bit mask
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : laneMask
  // register hit with access route check
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs,
                               input logic ok);
    hit = ok && (a == ofs);
  endfunction : hit
  // ----------------------------------------------------------------
  // access route
  // ----------------------------------------------------------------
  wire logic isLeadPort = (portNum == LEAD_PORT0) || (portNum == LEAD_PORT16) ||
                          (portNum == LEAD_PORT20); // station-leading port
  wire logic baseOk = isLeadPort && (leadPortIsNt ? fromNtVirtual : !fromNtVirtual); // [R12]
  wire logic routeOk = virtSwitchMode ? fromMgmtPort : baseOk; // [R11]
  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire logic [31:0] wrBits = cfgWrData & laneMask(cfgByteEn); // enabled data bits
  wire logic wrCorrSts = cfgWrEn && hit(cfgAddr, CORR_STATUS_OFS, routeOk);
  wire logic wrCorrMsk = cfgWrEn && hit(cfgAddr, CORR_MASK_OFS, routeOk);
  wire logic wrUncSts = cfgWrEn && hit(cfgAddr, UNC_STATUS_OFS, routeOk);
  wire logic wrUncMsk = cfgWrEn && hit(cfgAddr, UNC_MASK_OFS, routeOk);
  wire logic [31:0] corrClr = wrCorrSts ? wrBits : 32'h00000000; // [R16]
  wire logic [31:0] uncClr = wrUncSts ? wrBits : 32'h00000000; // [R7]
  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // remote ram error lands on the bit of the ingress station
  logic [31:0] remoteBits; // one-hot remote station bit
  always_comb begin
    remoteBits = 32'h00000000;
    if (remoteHdrErr) begin
      case (remoteStation)
        STN0: remoteBits[HDR_BIT_STN0] = 1'b1; // [R2]
        STN4: remoteBits[HDR_BIT_STN4] = 1'b1; // [R2]
        STN5: remoteBits[HDR_BIT_STN5] = 1'b1; // [R2]
        default: remoteBits = 32'h00000000; // no such station
      endcase
    end
  end
  // local egress checks plus remote reads, both reported here
  wire logic [31:0] uncSet = (uncEvent | remoteBits) & UNC_BITS; // [R1] [R3] [R4] [R5] [R6]
  wire logic [31:0] corrSet = corrEvent & CORR_STATUS_BITS; // [R16] [R17]
  // ----------------------------------------------------------------
  // sticky status registers
  // ----------------------------------------------------------------
  logic [31:0] corrStatus; // correctable status
  logic [31:0] uncStatus; // uncorrectable status
  rcesm_sticky_reg uCorrSts (
    .sys_clk(sys_clk),
    .rst(rst),
    .setBits(corrSet),
    .clrBits(corrClr),
    .implBits(CORR_STATUS_BITS),
    .status(corrStatus)
  );
  rcesm_sticky_reg uUncSts (
    .sys_clk(sys_clk),
    .rst(rst),
    .setBits(uncSet),
    .clrBits(uncClr),
    .implBits(UNC_BITS),
    .status(uncStatus)
  );
  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  logic [31:0] corrMask; // correctable mask
  logic [31:0] uncMask; // uncorrectable mask
  wire logic [31:0] laneSel = laneMask(cfgByteEn); // written lanes
  wire logic [31:0] next_corrMask = wrCorrMsk ?
    (((corrMask & ~laneSel) | wrBits) & CORR_MASK_BITS) : corrMask; // [R9] [R10]
  wire logic [31:0] next_uncMask = wrUncMsk ?
    (((uncMask & ~laneSel) | wrBits) & UNC_BITS) : uncMask; // [R8] [R10] [R19]
  // only the fundamental reset restores defaults
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      corrMask <= CORR_MASK_RST; // [R17] [R18]
      uncMask <= UNC_MASK_RST; // [R18]
    end else begin
      corrMask <= next_corrMask;
      uncMask <= next_uncMask;
    end
  end
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire logic [31:0] rdMux =
    hit(cfgAddr, CORR_STATUS_OFS, routeOk) ? corrStatus :
    hit(cfgAddr, CORR_MASK_OFS, routeOk) ? corrMask :
    hit(cfgAddr, UNC_STATUS_OFS, routeOk) ? uncStatus :
    hit(cfgAddr, UNC_MASK_OFS, routeOk) ? uncMask : 32'h00000000; // [R19]
  // registered read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgRdData <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdData <= cfgRdEn ? rdMux : 32'h00000000;
      cfgRdValid <= cfgRdEn;
    end
  end
  // ----------------------------------------------------------------
  // message request
  // ----------------------------------------------------------------
  wire logic unmaskedAny = (|(uncStatus & ~uncMask)) || (|(corrStatus & ~corrMask)); // [R13]
  wire logic reportable = unmaskedAny && uncIntErrStatus; // [R14]
  logic reportPrev; // reportable last cycle
  wire logic reportRise = reportable && !reportPrev; // new reportable error
  // one pulse per new reportable condition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reportPrev <= 1'b0;
      errFatalMsg <= 1'b0;
      errNonFatalMsg <= 1'b0;
    end else begin
      reportPrev <= reportable;
      errFatalMsg <= reportRise && intErrFatal && fatalReportEn; // [R15]
      errNonFatalMsg <= reportRise && !intErrFatal && nonFatalReportEn; // [R15]
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    uncSet[HDR_BIT_STN0] |=> uncStatus[HDR_BIT_STN0])
    else $error("uncorrectable status bit lost its event");
  AST_W1C: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (uncClr[HDR_BIT_STN4] && !uncSet[HDR_BIT_STN4]) |=> !uncStatus[HDR_BIT_STN4])
    else $error("write one did not clear status");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (uncStatus[2] && !uncClr[2]) |=> uncStatus[2])
    else $error("status bit dropped without clear");
  AST_REMOTE: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (remoteHdrErr && remoteStation == STN5) |=> uncStatus[HDR_BIT_STN5])
    else $error("remote station error not flagged");
  AST_MASK_RST: assert property (@(posedge sys_clk) // [R8]
    $past(rst) |-> (uncMask == UNC_MASK_RST && corrMask == CORR_MASK_RST))
    else $error("mask reset value wrong");
  AST_RSVD: assert property (@(posedge sys_clk) disable iff (rst) // [R19]
    ((uncStatus | uncMask) & ~UNC_BITS) == 32'h00000000)
    else $error("reserved bit set");
  AST_MASKED_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    (!unmaskedAny) |=> !(errFatalMsg || errNonFatalMsg))
    else $error("message from masked error");
  AST_NEED_INT: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
    (errFatalMsg || errNonFatalMsg) |-> $past(uncIntErrStatus))
    else $error("message without internal error status");
  AST_FATAL_EN: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    (reportRise && intErrFatal && fatalReportEn) |=> errFatalMsg ##1 !errFatalMsg)
    else $error("fatal message not a single pulse");
  AST_ROUTE: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (cfgRdEn && !routeOk) |=> (cfgRdValid && cfgRdData == 32'h00000000))
    else $error("refused route returned data");
  AST_NONFATAL_EN: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    (reportRise && !intErrFatal && nonFatalReportEn) |=> errNonFatalMsg ##1 !errNonFatalMsg)
    else $error("non-fatal message not a single pulse");
  AST_NO_ENABLE: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    (!fatalReportEn && !nonFatalReportEn) |=> !(errFatalMsg || errNonFatalMsg))
    else $error("message sent with reporting disabled");
  AST_CORR_SET: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
    corrSet[14] |=> corrStatus[14])
    else $error("correctable status bit lost its event");
  AST_MASK_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    !wrUncMsk |=> $stable(uncMask))
    else $error("uncorrectable mask changed without a write");
endmodule : rcesm_bank

// >>> verification/rcesm_bank_tb_top.sv
// Purpose: self-checking bench for the ram ecc error status and mask bank
// Assumes: single-cycle config strobes, read data one cycle after the strobe
// Notes: inputs driven by non-blocking assignment at the rising edge, or 1 ns after it when set after a read check
`timescale 1ns/1ns
module rcesm_bank_tb_top;
  import rcesm_pkg::*;
  // ----------------------------------------------------------------
  // signals and design instance
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0; // core clock, 8 ns
  logic rst = 1'b1; // fundamental reset
  logic cfgWrEn = 1'b0, cfgRdEn = 1'b0, remoteHdrErr = 1'b0;
  logic [11:0] cfgAddr = 12'h000;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWrData = 32'h0, corrEvent = 32'h0, uncEvent = 32'h0, cfgRdData;
  logic virtSwitchMode = 1'b0, fromMgmtPort = 1'b0, fromNtVirtual = 1'b0, leadPortIsNt = 1'b0;
  logic [4:0] portNum = 5'h00; // access port
  logic [2:0] remoteStation = 3'h0; // ingress station of a remote error
  logic uncIntErrStatus = 1'b0, intErrFatal = 1'b1, fatalReportEn = 1'b0, nonFatalReportEn = 1'b0;
  logic cfgRdValid, errFatalMsg, errNonFatalMsg;
  int num_errors = 0, checked = 0, fatalCnt = 0, nonFatalCnt = 0;
  localparam int UNC_POS[12] = '{2, 6, 7, 8, 12, 13, 14, 15, 16, 17, 18, 19};
  rcesm_bank rcesm_bank_i (.sys_clk(sys_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .virtSwitchMode(virtSwitchMode), .fromMgmtPort(fromMgmtPort),
    .fromNtVirtual(fromNtVirtual), .leadPortIsNt(leadPortIsNt), .portNum(portNum),
    .corrEvent(corrEvent), .uncEvent(uncEvent), .remoteHdrErr(remoteHdrErr),
    .remoteStation(remoteStation), .uncIntErrStatus(uncIntErrStatus), .intErrFatal(intErrFatal),
    .fatalReportEn(fatalReportEn), .nonFatalReportEn(nonFatalReportEn),
    .errFatalMsg(errFatalMsg), .errNonFatalMsg(errNonFatalMsg));
  // clock toggles every half period
  always #4 sys_clk = ~sys_clk;
  // message pulse counters
  always @(posedge sys_clk) begin
    if (errFatalMsg === 1'b1) fatalCnt++;
    if (errNonFatalMsg === 1'b1) nonFatalCnt++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one write strobe with byte lanes
  task automatic wrReg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    cfgByteEn <= be;
    @(posedge sys_clk);
    cfgWrEn <= 1'b0;
  endtask : wrReg
  // one read strobe, data checked in the valid cycle
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge sys_clk);
    cfgRdEn <= 1'b0;
    #1;
    chk({31'h0, cfgRdValid}, 32'h1);
    chk(cfgRdData, exp);
  endtask : rdChk
  // one-cycle pulse on the uncorrectable sources
  task automatic pulseUnc(input logic [31:0] v);
    @(posedge sys_clk);
    uncEvent <= v;
    @(posedge sys_clk);
    uncEvent <= 32'h0;
    repeat (4) @(posedge sys_clk);
  endtask : pulseUnc
  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values and reserved bits
    rdChk(CORR_STATUS_OFS, STATUS_RST);
    rdChk(CORR_MASK_OFS, CORR_MASK_RST);
    rdChk(UNC_STATUS_OFS, STATUS_RST);
    rdChk(UNC_MASK_OFS, UNC_MASK_RST);
    wrReg(CORR_MASK_OFS, 32'hffffffff, 4'hf);
    rdChk(CORR_MASK_OFS, CORR_MASK_BITS);
    wrReg(UNC_MASK_OFS, 32'h0, 4'h1);
    rdChk(UNC_MASK_OFS, 32'h000ff100);
    wrReg(UNC_MASK_OFS, 32'hffffffff, 4'hf);
    rdChk(UNC_MASK_OFS, UNC_BITS);
    rdChk(12'h710, 32'h0);
    // every 2-bit source sets its own bit, write one clears
    foreach (UNC_POS[i]) begin
      pulseUnc(32'h1 << UNC_POS[i]);
      rdChk(UNC_STATUS_OFS, 32'h1 << UNC_POS[i]);
      wrReg(UNC_STATUS_OFS, 32'h1 << UNC_POS[i], 4'hf);
      rdChk(UNC_STATUS_OFS, 32'h0);
    end
    pulseUnc(32'h00000008);
    rdChk(UNC_STATUS_OFS, 32'h0);
    // remote ram errors flag the ingress station bit
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      remoteHdrErr <= 1'b1;
      remoteStation <= (s == 0) ? STN0 : (s == 1) ? STN4 : (s == 2) ? STN5 : 3'h1;
      @(posedge sys_clk);
      remoteHdrErr <= 1'b0;
      rdChk(UNC_STATUS_OFS, (s == 3) ? 32'h0 : 32'h1 << ((s == 0) ? 8 : (s == 1) ? 12 : 13));
      wrReg(UNC_STATUS_OFS, 32'hffffffff, 4'hf);
    end
    // correctable sources and write-one clear
    @(posedge sys_clk);
    corrEvent <= 32'h00004001;
    @(posedge sys_clk);
    corrEvent <= 32'h0;
    rdChk(CORR_STATUS_OFS, 32'h00004001);
    wrReg(CORR_STATUS_OFS, 32'h00004001, 4'hf);
    rdChk(CORR_STATUS_OFS, 32'h0);
    // event and write-one clear in the same cycle: the event wins
    fork
      pulseUnc(32'h00000040);
      wrReg(UNC_STATUS_OFS, 32'h00000040, 4'hf);
    join
    rdChk(UNC_STATUS_OFS, 32'h00000040);
    wrReg(UNC_STATUS_OFS, 32'h00000040, 4'hf);
    rdChk(UNC_STATUS_OFS, 32'h0);
    // message requests: fatal, non-fatal, internal status low, masked
    uncIntErrStatus <= 1'b1;
    fatalReportEn <= 1'b1;
    wrReg(UNC_MASK_OFS, UNC_BITS & ~32'h4, 4'hf);
    pulseUnc(32'h4);
    chk(32'(fatalCnt), 32'h1);
    wrReg(UNC_STATUS_OFS, 32'h4, 4'hf);
    intErrFatal <= 1'b0;
    fatalReportEn <= 1'b0;
    nonFatalReportEn <= 1'b1;
    pulseUnc(32'h4);
    chk(32'(nonFatalCnt), 32'h1);
    chk(32'(fatalCnt), 32'h1);
    wrReg(UNC_STATUS_OFS, 32'h4, 4'hf);
    uncIntErrStatus <= 1'b0;
    pulseUnc(32'h4);
    chk(32'(nonFatalCnt), 32'h1);
    wrReg(UNC_STATUS_OFS, 32'h4, 4'hf);
    wrReg(UNC_MASK_OFS, UNC_BITS, 4'hf);
    uncIntErrStatus <= 1'b1;
    pulseUnc(32'h4);
    chk(32'(nonFatalCnt), 32'h1);
    // unmasked correctable source also requests a message
    wrReg(CORR_MASK_OFS, CORR_MASK_BITS & ~32'h00004000, 4'hf);
    @(posedge sys_clk);
    corrEvent <= 32'h00004000;
    @(posedge sys_clk);
    corrEvent <= 32'h0;
    repeat (4) @(posedge sys_clk);
    chk(32'(nonFatalCnt), 32'h2);
    wrReg(CORR_STATUS_OFS, 32'h00004000, 4'hf);
    wrReg(CORR_MASK_OFS, CORR_MASK_BITS, 4'hf);
    // access routing
    portNum <= LEAD_PORT16;
    rdChk(UNC_MASK_OFS, UNC_BITS);
    portNum <= 5'h01;
    rdChk(UNC_MASK_OFS, 32'h0);
    wrReg(UNC_MASK_OFS, 32'h0, 4'hf);
    portNum <= LEAD_PORT16;
    rdChk(UNC_MASK_OFS, UNC_BITS);
    portNum <= LEAD_PORT20;
    leadPortIsNt <= 1'b1;
    rdChk(UNC_MASK_OFS, 32'h0);
    fromNtVirtual <= 1'b1;
    rdChk(UNC_MASK_OFS, UNC_BITS);
    virtSwitchMode <= 1'b1;
    rdChk(UNC_MASK_OFS, 32'h0);
    fromMgmtPort <= 1'b1;
    rdChk(UNC_STATUS_OFS, 32'h4);
    // fundamental reset in mid-run restores defaults
    wrReg(UNC_MASK_OFS, 32'h0, 4'hf);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdChk(UNC_STATUS_OFS, STATUS_RST);
    rdChk(UNC_MASK_OFS, UNC_MASK_RST);
    rdChk(CORR_MASK_OFS, CORR_MASK_RST);
    test_done;
  end
endmodule : rcesm_bank_tb_top
